//--- verilog/hvi_port_input_control.sv
// Purpose: Register side and front-end controls of one high-voltage input
// Assumes: Single clock pclk, APB slave, stop_mode from the power logic
// Notes:   Analog front-end controls are registered, one cycle behind
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Pin bit reads level only while the input buffer is on, else reads one
// - Pin input register is read-only
// - Digital enable switches the input buffer
// - Analog use forces buffer off in run
// - Test force keeps buffer on, not direct
// - Pull-up replaces pull-down under test force with pull select, in run only
// - Bypass powers down converter, direct only
// - Direct routes pin past divider
// - Analog enable links pin to ADC
// - Ratio field picks one of three dividers
module hvi_port_input_control (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Pin and power state
  input  wire logic                  pin_raw,
  input  wire logic                  stop_mode,
  // Analog front end
  output hvi_pkg::hvi_front_t        front
);
  import hvi_pkg::*;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic       dig_enable_reg;
  logic [7:0] routing_reg;
  logic [1:0] ratio_reg;
  logic       sync1_reg;
  logic       sync2_reg;
  logic       test_force;
  logic       adc_en;
  logic       direct;
  logic       pin_input_bit;
  logic       access;
  logic       mapped;
  hvi_front_t front_next;
  logic [31:0] rdata_next;

  assign access = psel && penable;
  assign test_force = routing_reg[HVI_BIT_TEST_FORCE];
  assign adc_en     = routing_reg[HVI_BIT_ADC_EN];
  assign direct     = routing_reg[HVI_BIT_DIRECT];

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // Writes to the status word or an unmapped word change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_enable_reg <= HVI_RST_DIG_ENABLE;
      routing_reg    <= HVI_RST_ROUTING;
      ratio_reg      <= HVI_RST_RATIO;
    end else if (access && pwrite) begin
      case (paddr)
        HVI_OFS_DIG_GATE: dig_enable_reg <= pwdata[HVI_BIT_DIG_ENABLE];
        HVI_OFS_ROUTING:  routing_reg    <= pwdata[7:0];
        HVI_OFS_RATIO:    ratio_reg      <= pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pin readback
  // ----------------------------------------------------------------------
  // In run mode the test force also exposes the level during analog use,
  // but not in direct connection where the buffer is off
  always_comb begin
    pin_input_bit = 1'b1;
    if (front_next.buffer_enable) begin
      pin_input_bit = sync2_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Front-end control
  // ----------------------------------------------------------------------
  always_comb begin
    front_next = '0;
    front_next.adc_connect = adc_en;
    if (!adc_en) begin
      front_next.buffer_enable = dig_enable_reg;
    end else if (stop_mode) begin
      front_next.buffer_enable = dig_enable_reg;
    end else begin
      front_next.buffer_enable = test_force && !direct;
    end
    front_next.direct_connect   = adc_en && direct;
    front_next.divider_in_path  = adc_en && !direct;
    front_next.converter_bypass = adc_en && direct &&
                                  routing_reg[HVI_BIT_BYPASS];
    front_next.pull_up = routing_reg[HVI_BIT_PULL_SEL] && test_force &&
                         !stop_mode;
    front_next.pull_down = !front_next.pull_up;
    case (ratio_reg)
      HVI_RATIO_HIGH: front_next.divider = HVI_DIV_HIGH;
      HVI_RATIO_LOW:  front_next.divider = HVI_DIV_LOW;
      default:        front_next.divider = HVI_DIV_12;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      front <= '0;
    end else begin
      front <= front_next;
    end
  end

  // ----------------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      HVI_OFS_PIN_STATUS: rdata_next[HVI_BIT_PIN_INPUT] = pin_input_bit;
      HVI_OFS_DIG_GATE:   rdata_next[HVI_BIT_DIG_ENABLE] = dig_enable_reg;
      HVI_OFS_ROUTING:    rdata_next[7:0] = routing_reg;
      HVI_OFS_RATIO:      rdata_next[1:0] = ratio_reg;
      default:            mapped = 1'b0;
    endcase
  end

  // Answer registered: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rdata_next : 32'h0000_0000;
    end
  end

endmodule // hvi_port_input_control

`default_nettype wire

//--- verilog/hvi_pkg.sv
// Purpose: Shared constants and types for the high-voltage input control
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Offsets are local choices; fields sit in the low byte
package hvi_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] HVI_OFS_PIN_STATUS = 12'h000;
  localparam logic [11:0] HVI_OFS_DIG_GATE   = 12'h004;
  localparam logic [11:0] HVI_OFS_ROUTING    = 12'h008;
  localparam logic [11:0] HVI_OFS_RATIO      = 12'h00c;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int HVI_BIT_PIN_INPUT  = 0;
  localparam int HVI_BIT_DIG_ENABLE = 0;
  localparam int HVI_BIT_TEST_FORCE = 7;
  localparam int HVI_BIT_PULL_SEL   = 6;
  localparam int HVI_BIT_BYPASS     = 5;
  localparam int HVI_BIT_DIRECT     = 4;
  localparam int HVI_BIT_ADC_EN     = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic       HVI_RST_DIG_ENABLE = 1'b0;
  localparam logic [7:0] HVI_RST_ROUTING    = 8'h00;
  localparam logic [1:0] HVI_RST_RATIO      = 2'h0;

  // Divider ratio encodings
  localparam logic [1:0] HVI_RATIO_HIGH = 2'h0;
  localparam logic [1:0] HVI_RATIO_LOW  = 2'h1;

  typedef enum logic [1:0] {
    HVI_DIV_HIGH,
    HVI_DIV_LOW,
    HVI_DIV_12
  } hvi_div_t;

  // Controls to the analog front end
  typedef struct packed {
    logic     buffer_enable;
    logic     adc_connect;
    logic     direct_connect;
    logic     divider_in_path;
    logic     converter_bypass;
    logic     pull_up;
    logic     pull_down;
    hvi_div_t divider;
  } hvi_front_t;

endpackage : hvi_pkg

//--- testbench/hvi_monitor.sv
// Purpose: Port checks of the high-voltage input control
// Assumes: Front outputs lag their cause by one clock
// Notes:   Bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module hvi_monitor (
  // Clock and bus
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         prdata,
  // Pin side
  input wire logic                pin_raw,
  input wire logic                stop_mode,
  input wire hvi_pkg::hvi_front_t front
);
  import hvi_pkg::*;
  logic rd_st;
  assign rd_st = psel && !penable && !pwrite && paddr == HVI_OFS_PIN_STATUS;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pull_excl: assert property ($past(presetn) |-> front.pull_up != front.pull_down)
    else $error("pull pair");
  a_pullup_run: assert property (front.pull_up |-> !$past(stop_mode))
    else $error("pull-up in stop");
  a_direct_adc: assert property (front.direct_connect |-> front.adc_connect)
    else $error("direct without adc");
  a_div_path: assert property (front.adc_connect |-> front.divider_in_path != front.direct_connect)
    else $error("divider path");
  a_bypass_dir: assert property (front.converter_bypass |-> front.direct_connect)
    else $error("bypass not direct");
  a_direct_nobuf: assert property (front.direct_connect && !$past(stop_mode) |-> !front.buffer_enable)
    else $error("buffer on direct");
  a_status_off: assert property (rd_st ##1 !front.buffer_enable |-> prdata == 32'h0000_0001)
    else $error("status not one");
  a_status_sync: assert property ($stable(pin_raw) [*3] ##0 rd_st ##1 front.buffer_enable |-> prdata[0] == $past(pin_raw))
    else $error("status level");
  cover property (front.adc_connect && front.converter_bypass);
  cover property (front.pull_up);
  cover property (rd_st ##1 front.buffer_enable);
endmodule // hvi_monitor
`default_nettype wire

//--- testbench/hvi_pin_model.sv
// Purpose: Pin front end behind the input control
// Assumes: Bench chooses a driven or floating pin
// Notes:   A floating pin follows the active pull device
`timescale 1ns/1ps
`default_nettype none
module hvi_pin_model (
  // Bench side
  input  wire logic                drive_en,
  input  wire logic                drive_val,
  // Front end
  input  wire hvi_pkg::hvi_front_t front,
  output logic                     pin_raw
);
  import hvi_pkg::*;
  assign pin_raw = drive_en ? drive_val : front.pull_up;
endmodule // hvi_pin_model
`default_nettype wire

//--- testbench/hvi_port_input_control_tb.sv
// Purpose: Self-checking bench of the high-voltage input control
// Assumes: Zero-wait APB slave, reads queued as expectations
// Notes:   Random routing, enable, stop and pin from an LFSR
`timescale 1ns/1ps
`default_nettype none
module hvi_port_input_control_tb;
  import hvi_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic pin_raw, stop_mode, drive_en, drive_val;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  hvi_front_t front;
  logic [32:0] q[$];
  int n_errors, checks_done;
  hvi_port_input_control hvi_port_input_control_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_raw, .stop_mode, .front);
  hvi_pin_model hvi_pin_model_i (.drive_en, .drive_val, .front, .pin_raw);
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction
  task automatic cmp(input logic [32:0] g, input logic [32:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) q.push_back(e);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      end_of_test();
    end
    {psel, penable} <= 2'b00;
  endtask
  // Each read answer is matched with the oldest queued expectation
  always @(posedge pclk) if (pready === 1'b1 && !pwrite && q.size() > 0) begin
    cmp({pslverr, prdata}, q.pop_front());
  end
  initial begin
    logic [7:0] r;
    logic d, s, be, pin;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {stop_mode, drive_en, drive_val, n_errors, checks_done} = '0;
    rnd = 32'h0000_130c;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, HVI_OFS_PIN_STATUS, 0, 33'h0_0000_0001);
    apb(0, HVI_OFS_DIG_GATE, 0, 0);
    apb(0, 12'h010, 0, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++) begin
      apb(1, HVI_OFS_RATIO, i, 0);
      apb(0, HVI_OFS_RATIO, 0, i);
      cmp(front.divider, i[1] ? HVI_DIV_12 : i[1:0]);
    end
    for (int k = 0; k < 48; k++) begin
      rnd = lfsr(rnd);
      {s, d, r} = rnd[9:0];
      drive_en <= rnd[10];
      drive_val <= rnd[11];
      apb(1, HVI_OFS_DIG_GATE, {31'h0, d}, 0);
      apb(1, HVI_OFS_ROUTING, {24'h0, r}, 0);
      apb(1, HVI_OFS_PIN_STATUS, 32'hffff_ffff, 0);
      stop_mode <= s;
      repeat (5) @(posedge pclk);
      be = r[3] ? (s ? d : r[7] && !r[4]) : d;
      pin = rnd[10] ? rnd[11] : r[7] && r[6] && !s;
      cmp(front.buffer_enable, be);
      cmp(front.pull_up, r[7] && r[6] && !s);
      cmp({front.adc_connect, front.direct_connect, front.converter_bypass},
          {r[3], r[3] && r[4], r[3] && r[4] && r[5]});
      cmp({front.divider_in_path, front.pull_down},
          {r[3] && !r[4], !(r[7] && r[6] && !s)});
      apb(0, HVI_OFS_PIN_STATUS, 0, {32'h0, be ? pin : 1'b1});
      apb(0, HVI_OFS_ROUTING, 0, {25'h0, r});
    end
    end_of_test();
  end
endmodule // hvi_port_input_control_tb
bind hvi_port_input_control hvi_monitor hvi_monitor_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pin_raw, .stop_mode, .front);
`default_nettype wire
